/* fcsr_defs.vh */
// Purpose: Constants for the floating-point control and status register set
// Assumes: Included by fcsr_regs.v only
// Notes:   Offsets are register indices, byte address is four times the index
`ifndef FCSR_DEFS_VH
`define FCSR_DEFS_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define FCSR_IDX_STATUS      12'h822
`define FCSR_IDX_CONTROL     12'h824
`define FCSR_ADDR_STATUS     14'h2088
`define FCSR_ADDR_CONTROL    14'h2090

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define FCSR_STATUS_RESET    32'h00000000
`define FCSR_CONTROL_RESET   32'h00000000
`define FCSR_CONTROL_MASK    32'h0000FF70
`define FCSR_STATUS_MASK     32'h0F00FFF8
`define FCSR_DEFAULT_NAN     64'h7FFFFFFFFFFFFFFF

// ****************************************************************
// Field positions
// ****************************************************************
`define FCSR_TRAP_HI         15
`define FCSR_TRAP_LO         8
`define FCSR_ROUNDING_WIDTH_SELECT_BIT        6
`define FCSR_RND_HI          5
`define FCSR_RND_LO          4
`define FCSR_CC_HI           27
`define FCSR_CC_LO           24
`define FCSR_EXC_HI          15
`define FCSR_EXC_LO          8
`define FCSR_ACC_HI          7
`define FCSR_ACC_LO          3

// Fault byte bit order
`define FCSR_F_UNORD         7
`define FCSR_F_INNAN         6
`define FCSR_F_OPERAND_ERROR         5
`define FCSR_F_OVERFLOW_FLAG          4
`define FCSR_F_UNDERFLOW_FLAG          3
`define FCSR_F_DZ            2
`define FCSR_F_PRECISION_LOSS          1
`define FCSR_F_IDE           0

// Accrued byte bit order
`define FCSR_A_IOP           4
`define FCSR_A_OVERFLOW_FLAG          3
`define FCSR_A_UNDERFLOW_FLAG          2
`define FCSR_A_DZ            1
`define FCSR_A_PRECISION_LOSS          0

`endif

/* fcsr_regs.v */
// Purpose: Architectural data, control and status registers of the float unit
// Assumes: Single core clock sys_clk at 20 MHz, pipeline drives all strobes
// Notes:   Datapath, rounding and instruction address register live elsewhere
//
// Behaviour
// - Eight 64-bit data registers always hold double-precision values.
// - External operands are widened to double before storing or use.
// - Reset or null restore loads every data register with positive quiet NaN.
// - Control bits 15..8 are trap enables in fixed class order.
// - Each enable gates its own class; move and restore access control.
// - Reset or null restore clears control; all-zero control never traps.
// - Control bit 6 selects single (1) or double (0) rounding precision.
// - Control bits 5..4 select nearest, zero, down or up rounding.
// - Reserved control bits read zero; software keeps them cleared.
// - Status fully move/restore accessible; reset or null restore clears it.
// - Status bits 27..24 hold N, Z, I, NaN after arithmetic completes.
// - Stores, multi-register moves and system moves keep condition codes.
// - Status bits 15..8 hold the latest fault byte in trap order.
// - Fault byte cleared per capable operation; branch touches only unordered bit.
// - Operations unable to fault leave the fault byte untouched.
// - Arithmetic end ORs fault combinations into accrued bits 7..3.
// - Accrued bits stay set until status write, reset or null restore.
// - Writing accrued bits neither raises nor blocks a trap.
// - Accrued overflow, divide and precision OR in matching fault bits.
// - Accrued invalid ORs three faults; underflow ORs underflow AND precision.
`include "fcsr_defs.vh"
`default_nettype none

module fcsr_regs (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        null_restore,
    input  wire        data_wr,
    input  wire [2:0]  data_wr_sel,
    input  wire        data_wr_single,
    input  wire [63:0] data_wr_value,
    input  wire [2:0]  data_rd_sel,
    output reg  [63:0] data_rd_value,
    input  wire        ctl_wr,
    input  wire [11:0] ctl_idx,
    input  wire [31:0] ctl_wdata,
    output reg  [31:0] ctl_rdata,
    input  wire        arith_done,
    input  wire [3:0]  arith_cc,
    input  wire [7:0]  arith_faults,
    input  wire        move_done,
    input  wire [7:0]  move_faults,
    input  wire        branch_done,
    input  wire        branch_unordered,
    output wire        rounding_width_select,
    output wire [1:0]  rounding_mode_select,
    output wire        trap_request
);

// ****************************************************************
// Storage
// ****************************************************************
reg  [63:0] float_data_regs [0:7];
reg  [31:0] float_control;
reg  [31:0] float_status;
reg  [7:0]  next_fault;
reg  [4:0]  next_accrued;
reg  [3:0]  next_cc;
integer     i;

wire [7:0]  trap_enable_byte   = float_control[`FCSR_TRAP_HI:`FCSR_TRAP_LO];
wire [7:0]  current_fault_byte = float_status[`FCSR_EXC_HI:`FCSR_EXC_LO];
wire [4:0]  accrued_fault_byte = float_status[`FCSR_ACC_HI:`FCSR_ACC_LO];
wire [3:0]  condition_code_byte = float_status[`FCSR_CC_HI:`FCSR_CC_LO];
wire        wr_status  = ctl_wr && (ctl_idx == `FCSR_IDX_STATUS);
wire        wr_control = ctl_wr && (ctl_idx == `FCSR_IDX_CONTROL);

// Widen a single operand to double; exponent rebiased, specials kept
function [63:0] fcsr_widen;
    input [31:0] s;
    reg   [10:0] e;
    begin
        if (s[30:23] == 8'hFF) begin
            e = 11'h7FF;
        end else if (s[30:23] == 8'h00) begin
            e = 11'h000;  // Denormals become zero, hardware has no denormal support
        end else begin
            e = {3'h0, s[30:23]} + 11'h380;
        end
        if (s[30:23] == 8'h00) begin
            fcsr_widen = {s[31], 63'h0};
        end else begin
            fcsr_widen = {s[31], e, s[22:0], 29'h0};
        end
    end
endfunction

// ****************************************************************
// Control outputs
// ****************************************************************
assign rounding_width_select = float_control[`FCSR_ROUNDING_WIDTH_SELECT_BIT];
assign rounding_mode_select  = float_control[`FCSR_RND_HI:`FCSR_RND_LO];
// Trap follows the fault byte only; accrued bits have no path here
assign trap_request = |(current_fault_byte & trap_enable_byte);

// ****************************************************************
// Data registers
// ****************************************************************
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        for (i = 0; i < 8; i = i + 1) begin
            float_data_regs[i] <= `FCSR_DEFAULT_NAN;
        end
    end else if (null_restore) begin
        for (i = 0; i < 8; i = i + 1) begin
            float_data_regs[i] <= `FCSR_DEFAULT_NAN;
        end
    end else if (data_wr) begin
        // Always stored as double
        float_data_regs[data_wr_sel] <= data_wr_single ?
            fcsr_widen(data_wr_value[31:0]) : data_wr_value;
    end
end

// Registered read port
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        data_rd_value <= 64'h0000000000000000;
    end else begin
        data_rd_value <= float_data_regs[data_rd_sel];
    end
end

// ****************************************************************
// Control register
// ****************************************************************
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        float_control <= `FCSR_CONTROL_RESET;
    end else if (null_restore) begin
        float_control <= `FCSR_CONTROL_RESET;
    end else if (wr_control) begin
        float_control <= ctl_wdata & `FCSR_CONTROL_MASK;
    end
end

// ****************************************************************
// Status next-state
// ****************************************************************
// Priority: software write, then arithmetic, then move, then branch
always @* begin
    next_cc      = condition_code_byte;
    next_fault   = current_fault_byte;
    next_accrued = accrued_fault_byte;
    if (arith_done) begin
        next_cc    = arith_cc;
        next_fault = arith_faults;
    end else if (move_done) begin
        next_fault = move_faults;
    end else if (branch_done) begin
        next_fault[`FCSR_F_UNORD] = branch_unordered;
    end
    if (arith_done || move_done) begin
        next_accrued[`FCSR_A_IOP] = accrued_fault_byte[`FCSR_A_IOP]
            | next_fault[`FCSR_F_UNORD] | next_fault[`FCSR_F_INNAN]
            | next_fault[`FCSR_F_OPERAND_ERROR];
        next_accrued[`FCSR_A_OVERFLOW_FLAG] = accrued_fault_byte[`FCSR_A_OVERFLOW_FLAG]
            | next_fault[`FCSR_F_OVERFLOW_FLAG];
        next_accrued[`FCSR_A_UNDERFLOW_FLAG] = accrued_fault_byte[`FCSR_A_UNDERFLOW_FLAG]
            | (next_fault[`FCSR_F_UNDERFLOW_FLAG] & next_fault[`FCSR_F_PRECISION_LOSS]);
        next_accrued[`FCSR_A_DZ] = accrued_fault_byte[`FCSR_A_DZ]
            | next_fault[`FCSR_F_DZ];
        next_accrued[`FCSR_A_PRECISION_LOSS] = accrued_fault_byte[`FCSR_A_PRECISION_LOSS]
            | next_fault[`FCSR_F_PRECISION_LOSS];
    end else if (branch_done) begin
        // Branch only updates invalid operation
        next_accrued[`FCSR_A_IOP] = accrued_fault_byte[`FCSR_A_IOP]
            | branch_unordered;
    end
end

// ****************************************************************
// Status register
// ****************************************************************
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        float_status <= `FCSR_STATUS_RESET;
    end else if (null_restore) begin
        float_status <= `FCSR_STATUS_RESET;
    end else if (wr_status) begin
        // Software write replaces everything, accrued bits included
        float_status <= ctl_wdata & `FCSR_STATUS_MASK;
    end else begin
        float_status <= {4'h0, next_cc, 8'h00, next_fault, next_accrued, 3'h0};
    end
end

// ****************************************************************
// Register read
// ****************************************************************
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        ctl_rdata <= 32'h00000000;
    end else if (ctl_idx == `FCSR_IDX_STATUS) begin
        ctl_rdata <= float_status;
    end else if (ctl_idx == `FCSR_IDX_CONTROL) begin
        ctl_rdata <= float_control;
    end else begin
        ctl_rdata <= 32'h00000000;
    end
end

endmodule // fcsr_regs

`default_nettype wire

/* fcsr_regs_properties.sv */
// Purpose: Port assertions for the float register set
// Assumes: One clock, async high reset
// Notes:   Enable byte and mode bits are shadowed to predict outputs
`default_nettype none
module fcsr_regs_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        null_restore,
    input wire logic        ctl_wr,
    input wire logic [11:0] ctl_idx,
    input wire logic [31:0] ctl_wdata,
    input wire logic [31:0] ctl_rdata,
    input wire logic        arith_done,
    input wire logic [7:0]  arith_faults,
    input wire logic        move_done,
    input wire logic [7:0]  move_faults,
    input wire logic        branch_done,
    input wire logic        rounding_width_select,
    input wire logic [1:0]  rounding_mode_select,
    input wire logic        trap_request
);
    logic [7:0] en;
    logic [2:0] wq;
    logic       cw;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    assign cw = ctl_wr && ctl_idx == 12'h824 && !null_restore;
    // Shadows, since the enable byte is not visible at the ports
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en <= 8'h00;
            wq <= 3'h0;
        end else begin
            wq <= ctl_wdata[6:4];
            if (null_restore || (ctl_wr && ctl_idx == 12'h824)) begin
                en <= null_restore ? 8'h00 : ctl_wdata[15:8];
            end
        end
    end
    AST_TRAP_ZERO: assert property (cw && ctl_wdata == 32'h0 |=> !trap_request)
        else $error("trap with cleared control");
    AST_NULL_CLR: assert property (null_restore |=> !trap_request && rounding_mode_select == 2'h0
        && !rounding_width_select) else $error("null restore left control set");
    AST_RND: assert property (cw |=> rounding_mode_select == wq[1:0])
        else $error("rounding mode not taken");
    AST_ROUNDING_WIDTH_SELECT: assert property (cw |=> rounding_width_select == wq[2])
        else $error("precision not taken");
    AST_RSV: assert property (ctl_idx == 12'h824 |=> (ctl_rdata & 32'hFFFF008F) == 32'h0)
        else $error("reserved control bit reads one");
    AST_ARITH_TRAP: assert property (arith_done && !ctl_wr && !null_restore
        |=> trap_request == |($past(arith_faults) & en)) else $error("trap after arith wrong");
    AST_MOVE_TRAP: assert property (move_done && !arith_done && !ctl_wr && !null_restore
        |=> trap_request == |($past(move_faults) & en)) else $error("trap after move wrong");
    AST_STABLE: assert property (!(ctl_wr | arith_done | move_done | branch_done | null_restore)
        |=> $stable(trap_request)) else $error("trap moved while idle");
    COV_TRAP: cover property (arith_done ##1 trap_request);
    COV_NULL: cover property (null_restore);
    COV_BRANCH: cover property (branch_done);
endmodule // fcsr_regs_properties
bind fcsr_regs fcsr_regs_properties u_props (.*);
`default_nettype wire

/* fcsr_pipe_model.sv */
// Purpose: Pipeline model issuing completion pulses to the register set
// Assumes: One request per go pulse
// Notes:   Idle payload toggles so stale values are never trusted
`default_nettype none
module fcsr_pipe_model (
    input  wire logic       sys_clk,
    input  wire logic       op_go,
    input  wire logic [1:0] op_kind,
    input  wire logic [7:0] op_faults,
    output var logic        arith_done,
    output var logic [3:0]  arith_cc,
    output var logic [7:0]  arith_faults,
    output var logic        move_done,
    output var logic [7:0]  move_faults,
    output var logic        branch_done,
    output var logic        branch_unordered
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {arith_done, arith_cc, arith_faults, move_done, move_faults} = 22'h0;
    initial {branch_done, branch_unordered} = 2'h0;
    // Completion one cycle after the request, launched just after the edge
    always @(posedge sys_clk) begin
        arith_done       <= #1 op_go && op_kind == 2'h0;
        move_done        <= #1 op_go && op_kind == 2'h1;
        branch_done      <= #1 op_go && op_kind == 2'h2;
        arith_faults     <= #1 op_go ? op_faults : ~arith_faults;
        move_faults      <= #1 op_go ? op_faults : ~move_faults;
        branch_unordered <= #1 op_go ? op_faults[7] : ~branch_unordered;
        arith_cc         <= #1 op_go ? 4'hA : ~arith_cc;
    end
endmodule // fcsr_pipe_model
`default_nettype wire

/* fcsr_regs_bench.sv */
// Purpose: Self-checking bench for the float register set
// Assumes: Control port reads answer one cycle after the index
// Notes:   Pipeline completions come from the partner model
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module fcsr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, rst = 1, null_restore = 0, ctl_wr = 0, op_go = 0;
    logic        data_wr = 0, data_wr_single = 0;
    logic [2:0]  data_wr_sel = 0, data_rd_sel = 0;
    logic [63:0] data_wr_value = 0, data_rd_value;
    logic [11:0] ctl_idx = 0;
    logic [31:0] ctl_wdata = 0, ctl_rdata;
    logic [1:0]  op_kind = 0, rounding_mode_select;
    logic [7:0]  op_faults = 0, arith_faults, move_faults;
    logic [3:0]  arith_cc;
    logic        arith_done, move_done, branch_done, branch_unordered;
    logic        rounding_width_select, trap_request;
    int          fails = 0, checks = 0, cyc = 0;
    fcsr_regs dut (.*);
    fcsr_pipe_model u_pipe (.*);
    always #25 sys_clk = ~sys_clk;
    // Cut a hang short; the run needs under a hundred cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        @(posedge sys_clk) #1;
        {ctl_wr, ctl_idx, ctl_wdata} = {1'b1, i, d};
        @(posedge sys_clk) #1;
        ctl_wr = 0;
    endtask
    task automatic chk_rd(input logic [11:0] i, input logic [31:0] e);
        @(posedge sys_clk) #1;
        ctl_idx = i;
        @(posedge sys_clk) #1;
        `CHK(ctl_rdata, e)
    endtask
    task automatic op(input logic [1:0] k, input logic [7:0] f);
        @(posedge sys_clk) #1;
        {op_go, op_kind, op_faults} = {1'b1, k, f};
        @(posedge sys_clk) #1;
        op_go = 0;
    endtask
    task automatic pulse_null;
        @(posedge sys_clk) #1;
        null_restore = 1;
        @(posedge sys_clk) #1;
        null_restore = 0;
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence: reset state, control fields, fault tracking, restore
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst = 0;
        chk_rd(12'h822, 32'h0);
        `CHK(data_rd_value, 64'h7FFFFFFFFFFFFFFF)
        wr(12'h824, 32'hFFFFFFFF);
        chk_rd(12'h824, 32'h0000FF70);
        for (int i = 0; i < 8; i++) begin
            wr(12'h824, 32'(i << 4));
            `CHK({rounding_width_select, rounding_mode_select}, 3'(i))
        end
        wr(12'h824, 32'h00001000);
        op(2'h0, 8'h12);
        chk_rd(12'h822, 32'h0A001248);
        `CHK(trap_request, 1'b1)
        op(2'h0, 8'h08);
        chk_rd(12'h822, 32'h0A000848);
        `CHK(trap_request, 1'b0)
        op(2'h1, 8'h20);
        chk_rd(12'h822, 32'h0A0020C8);
        op(2'h2, 8'h80);
        chk_rd(12'h822, 32'h0A00A0C8);
        wr(12'h822, 32'h000000F8);
        chk_rd(12'h822, 32'h000000F8);
        `CHK(trap_request, 1'b0)
        @(posedge sys_clk) #1;
        {data_wr, data_wr_sel, data_wr_single, data_rd_sel} = {1'b1, 3'h3, 1'b1, 3'h3};
        data_wr_value = 64'h3F800000;
        @(posedge sys_clk) #1;
        data_wr = 0;
        @(posedge sys_clk) #1;
        `CHK(data_rd_value, 64'h3FF0000000000000)
        wr(12'h824, 32'h00000070);
        pulse_null();
        chk_rd(12'h822, 32'h0);
        `CHK(data_rd_value, 64'h7FFFFFFFFFFFFFFF)
        chk_rd(12'h824, 32'h0);
        `CHK({rounding_width_select, rounding_mode_select}, 3'h0)
        print_verdict();
    end
endmodule // fcsr_regs_bench
`default_nettype wire
